// ### supply_supervisor.sv
// supply supervisor: reset generation, watchdog, power-fail, backup switch, chip-select gating
`timescale 1ns/1ps
`include "supsup_cfg.svh"

// Notes on behaviour
// - reset low while supply below trip, manual reset low or aux monitor low.
// - reset held for the hold time after every cause is removed.
// - kick static past the timeout fires a reset pulse of hold-time length.
// - watchdog cleared by reset and by either edge of the kick input.
// - processor toggles or pulses kick; any change restarts the watchdog.
// - static kick repeats reset pulses after each further timeout.
// - power-fail warning low while sensed level is under threshold.
// - power-fail warning forced low while supply is below trip.
// - aux monitor low asserts reset, held for hold time after recovery.
// - rail from main supply when above trip or above battery, else battery.
// - battery needs 40mV margin to take over; returns when supply above battery.
// - backup mode asserts reset and warning, ignores inputs, chip-select high.
// - no start-up from battery alone; rail first powered from main supply.
// - gated chip-select low only when input low and reset not asserted, or during the 1us drain at reset start.
// - input high at reset start keeps gated output high all reset.
// - input low at reset start holds output low 1us, then high.
// - disconnected chip-select path drives output high.
// - manual reset input debounced internally.
// - open manual reset input reads inactive high.
// - reset output push-pull or open-drain, chosen at build time.
module supply_supervisor #(
  parameter int unsigned RST_HOLD_CYC     = `RST_HOLD_CYC,
  parameter int unsigned KICK_TIMEOUT_CYC = `KICK_TIMEOUT_CYC,
  parameter int unsigned CS_HOLD_CYC      = `CS_HOLD_CYC,
  parameter int unsigned DEBOUNCE_CYC     = `DEBOUNCE_CYC,
  parameter bit          OPEN_DRAIN       = 1'b0
) (
  input  wire logic              I_REF_CLK,
  input  wire logic              I_ARST_N,
  input  wire logic              i_CLK_EN,
  input  wire supsup_pkg::pin_in_t i_PINS,
  output logic                   o_RESET_N,
  output logic                   o_RESET_OE,
  output logic                   o_POWERFAIL_WARN_N,
  output logic                   o_BACKUP_ACTIVE,
  output logic                   o_RAIL_FROM_MAIN,
  output logic                   o_CHIP_SEL_GATED_N
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  supsup_pkg::pin_in_t meta_q;
  supsup_pkg::pin_in_t sync_q;
  logic                kick_prev_q;

  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      // supply taken as low until seen, so reset alone never marks power-up
      meta_q      <= 8'h4a; // manual reset idles high
      sync_q      <= 8'h4a;
      kick_prev_q <= 1'b1; // matches the synchroniser's kick level, no false edge
    end else if (i_CLK_EN) begin
      meta_q      <= i_PINS;
      sync_q      <= meta_q;
      kick_prev_q <= sync_q.wdog_kick_in;
    end
  end

  // ----------------------------------------------------------------
  // backup switchover with hysteresis
  // ----------------------------------------------------------------
  logic powered_q;
  logic backup_q;
  wire  go_backup = !sync_q.supply_ok && sync_q.backup_above_supply_40mv;
  wire  go_main   = sync_q.supply_ok || sync_q.supply_above_backup;

  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      powered_q <= 1'b0;
      backup_q  <= 1'b0;
    end else if (i_CLK_EN) begin
      if (sync_q.supply_ok) begin
        powered_q <= 1'b1; // first power only from main supply
      end
      if (!powered_q) begin
        backup_q <= 1'b0;
      end else if (backup_q && go_main) begin
        backup_q <= 1'b0;
      end else if (!backup_q && go_backup) begin
        backup_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // manual reset debounce
  // ----------------------------------------------------------------
  logic [`CNT_W-1:0] deb_cnt_q;
  logic              mr_clean_n_q;
  wire               mr_differs = sync_q.manual_reset_n != mr_clean_n_q;
  wire               deb_done   = deb_cnt_q >= (`CNT_W)'(DEBOUNCE_CYC - 1);

  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      deb_cnt_q    <= '0;
      mr_clean_n_q <= 1'b1;
    end else if (i_CLK_EN) begin
      if (!mr_differs) begin
        deb_cnt_q <= '0;
      end else if (deb_done) begin
        deb_cnt_q    <= '0;
        mr_clean_n_q <= sync_q.manual_reset_n;
      end else begin
        deb_cnt_q <= deb_cnt_q + (`CNT_W)'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // reset causes and hold timer
  // ----------------------------------------------------------------
  logic [`CNT_W-1:0] wd_cnt_q;
  logic [`CNT_W-1:0] hold_cnt_q;
  logic              rst_q;

  wire in_gate    = !backup_q; // inputs ignored in backup
  wire mr_low     = in_gate && !mr_clean_n_q;
  wire aux_low    = in_gate && !sync_q.aux_monitor_in;
  wire cause_lvl  = !sync_q.supply_ok || mr_low || aux_low || backup_q;
  wire kick_edge  = in_gate && (sync_q.wdog_kick_in != kick_prev_q);
  wire wd_expire  = in_gate && !rst_q && (wd_cnt_q >= (`CNT_W)'(KICK_TIMEOUT_CYC - 1));
  wire hold_done  = hold_cnt_q >= (`CNT_W)'(RST_HOLD_CYC - 1);

  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rst_q      <= 1'b1;
      hold_cnt_q <= '0;
    end else if (i_CLK_EN) begin
      if (cause_lvl || wd_expire) begin
        rst_q      <= 1'b1;
        hold_cnt_q <= '0;
      end else if (rst_q) begin
        if (hold_done) begin
          rst_q <= 1'b0;
        end else begin
          hold_cnt_q <= hold_cnt_q + (`CNT_W)'(1);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // watchdog timer
  // ----------------------------------------------------------------
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      wd_cnt_q <= '0;
    end else if (i_CLK_EN) begin
      if (rst_q || kick_edge || wd_expire) begin
        wd_cnt_q <= '0;
      end else begin
        wd_cnt_q <= wd_cnt_q + (`CNT_W)'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // chip-select gating
  // ----------------------------------------------------------------
  supsup_pkg::cs_state_t cs_q;
  logic [`CS_W-1:0]      cs_cnt_q;
  logic                  cs_out_n_q;
  logic                  rst_prev_q;
  wire                   rst_rise = rst_q && !rst_prev_q;
  wire                   cs_in_n  = sync_q.chip_sel_in_n || backup_q;
  wire                   cs_done  = cs_cnt_q >= (`CS_W)'(CS_HOLD_CYC - 1);

  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      cs_q       <= supsup_pkg::CS_BLOCK;
      cs_cnt_q   <= '0;
      cs_out_n_q <= 1'b1;
      rst_prev_q <= 1'b1;
    end else if (i_CLK_EN) begin
      rst_prev_q <= rst_q;
      case (cs_q)
        supsup_pkg::CS_PASS: begin
          if (rst_rise && !cs_out_n_q && !backup_q) begin
            cs_q     <= supsup_pkg::CS_DRAIN;
            cs_cnt_q <= '0;
          end else if (rst_q) begin
            cs_q       <= supsup_pkg::CS_BLOCK;
            cs_out_n_q <= 1'b1;
          end else begin
            cs_out_n_q <= cs_in_n;
          end
        end
        supsup_pkg::CS_DRAIN: begin
          if (cs_done || backup_q) begin
            cs_q       <= supsup_pkg::CS_BLOCK;
            cs_out_n_q <= 1'b1;
          end else begin
            cs_cnt_q <= cs_cnt_q + (`CS_W)'(1);
          end
        end
        supsup_pkg::CS_BLOCK: begin
          cs_out_n_q <= 1'b1; // disconnected path driven high
          if (!rst_q) begin
            cs_q <= supsup_pkg::CS_PASS;
          end
        end
        default: begin
          cs_q       <= supsup_pkg::CS_BLOCK;
          cs_out_n_q <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // power-fail warning and outputs
  // ----------------------------------------------------------------
  logic pfw_n_q;

  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      pfw_n_q <= 1'b0;
    end else if (i_CLK_EN) begin
      pfw_n_q <= sync_q.powerfail_sense_in && sync_q.supply_ok && !backup_q;
    end
  end

  assign o_RESET_N          = OPEN_DRAIN ? 1'b0 : !rst_q;
  assign o_RESET_OE         = OPEN_DRAIN ? rst_q : 1'b1;
  assign o_POWERFAIL_WARN_N = pfw_n_q;
  assign o_BACKUP_ACTIVE    = backup_q;
  assign o_RAIL_FROM_MAIN   = powered_q && !backup_q;
  assign o_CHIP_SEL_GATED_N = cs_out_n_q;

endmodule : supply_supervisor

// ### supsup_cfg.svh
// timing and counter-width constants for the supply supervisor
`ifndef SUPSUP_CFG_SVH
`define SUPSUP_CFG_SVH
`define CLK_HZ            10000000
`define RST_HOLD_MS       140
`define KICK_TIMEOUT_MS   1600
`define CS_HOLD_NS        1000
`define DEBOUNCE_US       1000
`define RST_HOLD_CYC      ((`CLK_HZ / 1000) * `RST_HOLD_MS)
`define KICK_TIMEOUT_CYC  ((`CLK_HZ / 1000) * `KICK_TIMEOUT_MS)
`define CS_HOLD_CYC       ((`CS_HOLD_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define DEBOUNCE_CYC      ((`CLK_HZ / 1000000) * `DEBOUNCE_US)
`define CNT_W             24
`define CS_W              8
`endif

// ### supsup_pkg.sv
// types for the supply supervisor
package supsup_pkg;
  typedef enum logic [1:0] {
    CS_PASS  = 2'b00,
    CS_DRAIN = 2'b01,
    CS_BLOCK = 2'b10
  } cs_state_t;

  typedef struct packed {
    logic supply_ok;
    logic manual_reset_n;
    logic aux_monitor_in;
    logic powerfail_sense_in;
    logic wdog_kick_in;
    logic chip_sel_in_n;
    logic supply_above_backup;
    logic backup_above_supply_40mv;
  } pin_in_t;
endpackage : supsup_pkg

// ### supply_supervisor_props.sv
// port-level checks for the supply supervisor
`timescale 1ns/1ps
module supply_supervisor_props #(
  parameter int unsigned RST_HOLD_CYC = 20
) (
  input wire logic                I_REF_CLK,
  input wire logic                I_ARST_N,
  input wire logic                i_CLK_EN,
  input wire supsup_pkg::pin_in_t i_PINS,
  input wire logic                o_RESET_N,
  input wire logic                o_RESET_OE,
  input wire logic                o_POWERFAIL_WARN_N,
  input wire logic                o_BACKUP_ACTIVE,
  input wire logic                o_RAIL_FROM_MAIN,
  input wire logic                o_CHIP_SEL_GATED_N
);
  logic [31:0] low_cnt_q;
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_ARST_N);
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N)
    if (!I_ARST_N) low_cnt_q <= 32'h0;
    else low_cnt_q <= o_RESET_N ? 32'h0 : low_cnt_q + 32'h1;
  property p_cause_supply; !i_PINS.supply_ok [*4] |-> !o_RESET_N; endproperty
  a_cause_supply: assert property (p_cause_supply) else $error("reset not asserted on low supply");
  property p_cause_aux; !i_PINS.aux_monitor_in [*4] |-> !o_RESET_N; endproperty
  a_cause_aux: assert property (p_cause_aux) else $error("reset not asserted on low aux level");
  property p_release; $rose(o_RESET_N) |-> $past(i_PINS.supply_ok, 3) && $past(i_PINS.aux_monitor_in, 3); endproperty
  a_release: assert property (p_release) else $error("reset released with a cause present");
  property p_hold; $rose(o_RESET_N) |-> low_cnt_q >= RST_HOLD_CYC; endproperty
  a_hold: assert property (p_hold) else $error("reset pulse shorter than hold time");
  property p_warn_sense; !i_PINS.powerfail_sense_in [*4] |-> !o_POWERFAIL_WARN_N; endproperty
  a_warn_sense: assert property (p_warn_sense) else $error("warning not low on low sense");
  property p_warn_supply; !i_PINS.supply_ok [*4] |-> !o_POWERFAIL_WARN_N; endproperty
  a_warn_supply: assert property (p_warn_supply) else $error("warning not low on low supply");
  property p_cs_pass; !o_CHIP_SEL_GATED_N |-> !$past(i_PINS.chip_sel_in_n, 3) || !o_RESET_N; endproperty
  a_cs_pass: assert property (p_cs_pass) else $error("gated select low without request");
  property p_cs_block; !o_RESET_N && o_CHIP_SEL_GATED_N |=> o_CHIP_SEL_GATED_N || o_RESET_N; endproperty
  a_cs_block: assert property (p_cs_block) else $error("gated select reopened during reset");
  property p_cs_drain;
    $fell(o_RESET_N) && !o_CHIP_SEL_GATED_N && !o_BACKUP_ACTIVE |->
      !o_CHIP_SEL_GATED_N [*8] ##[1:4] o_CHIP_SEL_GATED_N;
  endproperty
  a_cs_drain: assert property (p_cs_drain) else $error("gated select drain length wrong");
  property p_backup; o_BACKUP_ACTIVE |-> !o_RESET_N && !o_POWERFAIL_WARN_N && !o_RAIL_FROM_MAIN; endproperty
  a_backup: assert property (p_backup) else $error("backup mode outputs wrong");
  property p_rail; i_PINS.supply_ok [*5] |-> o_RAIL_FROM_MAIN && !o_BACKUP_ACTIVE; endproperty
  a_rail: assert property (p_rail) else $error("rail not on main supply");
  property p_reset_drive; o_BACKUP_ACTIVE |-> o_RESET_OE && !o_RESET_N; endproperty
  a_reset_drive: assert property (p_reset_drive) else $error("reset pin not driven low in backup");
endmodule : supply_supervisor_props
bind supply_supervisor supply_supervisor_props #(.RST_HOLD_CYC(RST_HOLD_CYC)) props_u (
  .I_REF_CLK(I_REF_CLK), .I_ARST_N(I_ARST_N), .i_CLK_EN(i_CLK_EN), .i_PINS(i_PINS), .o_RESET_N(o_RESET_N),
  .o_RESET_OE(o_RESET_OE), .o_POWERFAIL_WARN_N(o_POWERFAIL_WARN_N), .o_BACKUP_ACTIVE(o_BACKUP_ACTIVE),
  .o_RAIL_FROM_MAIN(o_RAIL_FROM_MAIN), .o_CHIP_SEL_GATED_N(o_CHIP_SEL_GATED_N));

// ### cpu_sram_model.sv
// processor model driving the kick line and memory select
`timescale 1ns/1ps
module cpu_sram_model (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_kick_en,
  output logic      o_kick,
  output logic      o_cs_n
);
  int         seed = 15144;
  logic [3:0] div_q = 4'h0;
  initial o_kick = 1'b0;
  initial o_cs_n = 1'b1;
  always @(posedge i_clk) begin
    div_q  <= div_q + 4'h1;
    o_cs_n <= 1'($random(seed));
    if (i_rst_n && i_kick_en && div_q == 4'hf) o_kick <= ~o_kick;
  end
endmodule : cpu_sram_model

// ### supply_supervisor_tb_top.sv
// self-checking testbench for the supply supervisor
`timescale 1ns/1ps
module supply_supervisor_tb_top;
  localparam int HOLD = 20;
  localparam int WDT  = 50;
  logic clk = 1'b0, arst_n = 1'b0, sup_ok = 1'b1, man_n = 1'b1, aux = 1'b1, pfs = 1'b1;
  logic above = 1'b1, bat40 = 1'b0, kick_en = 1'b1;
  logic kick, cs_n, rst_n, warn_n, bat_on, rail, cs_g_n;
  int   err_total = 0, checks_done = 0, n;
  supsup_pkg::pin_in_t pins;
  assign pins = '{sup_ok, man_n, aux, pfs, kick, cs_n, above, bat40};
  supply_supervisor #(.RST_HOLD_CYC(HOLD), .KICK_TIMEOUT_CYC(WDT), .CS_HOLD_CYC(10), .DEBOUNCE_CYC(4)) dut_u (
    .I_REF_CLK(clk), .I_ARST_N(arst_n), .i_CLK_EN(1'b1), .i_PINS(pins), .o_RESET_N(rst_n), .o_RESET_OE(),
    .o_POWERFAIL_WARN_N(warn_n), .o_BACKUP_ACTIVE(bat_on), .o_RAIL_FROM_MAIN(rail), .o_CHIP_SEL_GATED_N(cs_g_n));
  cpu_sram_model cpu_u (.i_clk(clk), .i_rst_n(rst_n), .i_kick_en(kick_en), .o_kick(kick), .o_cs_n(cs_n));
  initial forever #50 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("errors=%0d checks=%0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  // bounded wait for the reset output to reach a level
  task automatic wait_rst(input logic lvl, input int bound, output int cyc);
    cyc = 0;
    while (rst_n !== lvl) begin
      @(negedge clk);
      cyc++;
      if (cyc > bound) begin
        err_total++;
        conclude();
      end
    end
  endtask : wait_rst
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    wait_rst(1'b1, HOLD + 10, n);
    chk(32'(n >= HOLD), 32'h1);
    for (int c = 0; c < 3; c++) begin
      @(posedge clk) {sup_ok, aux, man_n} <= ~(3'b100 >> c);
      wait_rst(1'b0, 12, n);
      if (c == 0) chk(32'(warn_n), 32'h0);
      repeat (6) @(posedge clk);
      {sup_ok, aux, man_n} <= 3'b111;
      wait_rst(1'b1, HOLD + 12, n);
      chk(32'(n >= HOLD), 32'h1);
    end
    @(posedge clk) pfs <= 1'b0;
    repeat (5) @(negedge clk);
    chk(32'({warn_n, rst_n}), 32'h1);
    @(posedge clk) pfs <= 1'b1;
    repeat (5) @(negedge clk);
    chk(32'(warn_n), 32'h1);
    @(posedge clk) kick_en <= 1'b0;
    wait_rst(1'b0, WDT + 8, n);
    wait_rst(1'b1, HOLD + 4, n);
    chk(32'(n >= HOLD - 2), 32'h1);
    wait_rst(1'b0, WDT + 8, n);
    wait_rst(1'b1, HOLD + 4, n);
    @(posedge clk) kick_en <= 1'b1;
    repeat (3 * WDT) begin
      @(negedge clk);
      chk(32'(rst_n), 32'h1);
    end
    @(posedge clk) {sup_ok, above, bat40, aux} <= 4'b0010;
    repeat (6) @(negedge clk);
    chk(32'({rst_n, warn_n, bat_on, rail, cs_g_n}), 32'h05);
    @(posedge clk) {above, bat40, aux} <= 3'b101;
    repeat (5) @(negedge clk);
    chk(32'({bat_on, rail}), 32'h1);
    @(posedge clk) {arst_n, above, bat40} <= 3'b001;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (8) @(negedge clk);
    chk(32'({bat_on, rail}), 32'h0);
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    conclude();
  end
endmodule : supply_supervisor_tb_top
